//--- multi_channel_pwm_core.sv
// Contract
// - Independent mode: eight channels share one period, each has its own duty.
// - Complementary mode: four pairs with dead zone, all pairs run together.
// - Edge mode: counter starts at zero, output toggles at duty match.
// - Edge mode: counter clears after period value, period is value plus one.
// - Center mode: counts up then down, toggles twice, twice the edge period.
// - Duty ratio equals duty value over period value plus one; center mode gives 2*duty-1 ticks high out of 2*(period+1).
// - Run bit clear stops unit, clears counter, returns pins to general I/O.
// - Overflow sets the flag; interrupt raised when overflow enable is set.
// - Flag is never cleared by hardware; software writes zero to clear.
// - Divider select picks oscillator clock divided by 1, 2, 4 or 8.
// - Mode upper bit picks complementary, lower bit picks center alignment.
// - Per-channel invert bit inverts that channel's waveform.
// - Per-channel output select routes waveform to its pin.
// - Period held as low and high bytes, both reset to zero.
// - Running with no outputs selected still works as a timer with interrupts.
// - Overflow interrupt enable gates the interrupt output.
//
// Implementation choice: the strobed register port.
`timescale 1ns/100ps

`include "pwm_regs.svh"

module multi_channel_pwm_core (
  // Clock and reset
  input  wire logic                 clk,
  input  wire logic                 resetn,
  // Register port
  input  wire pwm_pkg::bus_req_t    bus_req,
  output logic [7:0]                bus_rdata,
  // Pins and interrupt
  output pwm_pkg::pin_drive_t       pins,
  output logic                      irq
);

  import pwm_pkg::*;

  typedef struct packed {
    logic [7:0]       invert;
    logic             run;
    logic             ovf_flag;
    logic [1:0]       ckdiv;
    logic [1:0]       mode;
    logic [7:0]       out_sel;
    logic [15:0]      period;
    logic             ovf_irq_en;
    logic [7:0]       dead;
    logic [8*16-1:0]  duty;
    logic [15:0]      period_sh;
    logic [8*16-1:0]  duty_sh;
    logic [2:0]       prescale;
    logic [15:0]      cnt;
    count_dir_t       dir;
    logic [7:0]       wave;
    logic [7:0]       rdata;
    pin_drive_t       pins;
    logic             irq;
  } core_state_t;

  core_state_t st_r;
  core_state_t st_nxt;

  logic [7:0] dz_wave;
  logic [7:0] dz_in;
  logic [7:0] dz_time;

  // ============================================================
  // Dead-zone stages
  // Complementary pairs take the even channel's waveform and its inverse.
  always_comb begin
    for (int p = 0; p < 4; p++) begin
      if (st_r.mode[`BIT_MODE_COMP]) begin
        dz_in[2*p]   = st_r.wave[2*p];
        dz_in[2*p+1] = ~st_r.wave[2*p];
      end else begin
        dz_in[2*p]   = st_r.wave[2*p];
        dz_in[2*p+1] = st_r.wave[2*p+1];
      end
    end
    dz_time = st_r.mode[`BIT_MODE_COMP] ? st_r.dead : `RST_DEAD;
  end

  genvar g;
  generate
    for (g = 0; g < 8; g++) begin : g_dz
      pwm_channel u_chan (
        .clk       (clk),
        .resetn    (resetn),
        .wave_in   (dz_in[g]),
        .dead_time (dz_time),
        .wave_out  (dz_wave[g])
      );
    end
  endgenerate

  // ============================================================
  // Next-state logic
  always_comb begin
    logic [2:0]  mask;
    logic        tick;
    logic        ovf;
    logic [11:0] didx;
    mask   = `DIV_MASK_1;
    tick   = 1'b0;
    ovf    = 1'b0;
    didx   = 12'h000;
    st_nxt = st_r;

    // Prescaler
    case (st_r.ckdiv)
      2'h0:    mask = `DIV_MASK_1;
      2'h1:    mask = `DIV_MASK_2;
      2'h2:    mask = `DIV_MASK_4;
      2'h3:    mask = `DIV_MASK_8;
      default: mask = `DIV_MASK_1;
    endcase
    tick = st_r.run && ((st_r.prescale & mask) == mask);
    st_nxt.prescale = st_r.run ? st_r.prescale + 3'h1 : 3'h0;

    // Counter
    if (!st_r.run) begin
      st_nxt.cnt       = `RST_WORD;
      st_nxt.dir       = DIR_UP;
      st_nxt.period_sh = st_r.period;
      st_nxt.duty_sh   = st_r.duty;
    end else if (tick) begin
      if (!st_r.mode[`BIT_MODE_CENTER]) begin
        if (st_r.cnt >= st_r.period_sh) begin
          st_nxt.cnt = `RST_WORD;
          ovf        = 1'b1;
        end else begin
          st_nxt.cnt = st_r.cnt + 16'h0001;
        end
      end else begin
        case (st_r.dir)
          DIR_UP: begin
            st_nxt.cnt = st_r.cnt + 16'h0001;
            if (st_r.cnt >= st_r.period_sh) begin
              st_nxt.dir = DIR_DOWN;
            end
          end
          DIR_DOWN: begin
            st_nxt.cnt = st_r.cnt - 16'h0001;
            if (st_r.cnt <= 16'h0001) begin
              st_nxt.cnt = `RST_WORD;
              st_nxt.dir = DIR_UP;
              ovf        = 1'b1;
            end
          end
          default: st_nxt.dir = DIR_UP;
        endcase
      end
      // New settings only at the boundary, so a period is never torn
      if (ovf) begin
        st_nxt.period_sh = st_r.period;
        st_nxt.duty_sh   = st_r.duty;
      end
    end

    // Raw waveform: high until the duty match
    for (int c = 0; c < 8; c++) begin
      st_nxt.wave[c] = st_r.run && (st_r.cnt < st_r.duty_sh[16*c +: 16]);
    end

    // Pins: invert, then select; run clear hands all pins back
    for (int c = 0; c < 8; c++) begin
      st_nxt.pins.level[c]   = dz_wave[c] ^ st_r.invert[c];
      st_nxt.pins.drive_n[c] = ~(st_r.run && st_r.out_sel[c]);
    end

    // Register writes
    if (bus_req.wr) begin
      case (bus_req.addr)
        `OFS_CH_INVERT:  st_nxt.invert  = bus_req.wdata;
        `OFS_MAIN_CTRL: begin
          st_nxt.run      = bus_req.wdata[`BIT_MODULE_RUN];
          st_nxt.ovf_flag = bus_req.wdata[`BIT_OVF_FLAG];
          st_nxt.ckdiv    = bus_req.wdata[`BIT_CKDIV_HI:`BIT_CKDIV_LO];
          st_nxt.mode     = bus_req.wdata[`BIT_MODE_COMP:`BIT_MODE_CENTER];
        end
        `OFS_OUT_SELECT: st_nxt.out_sel = bus_req.wdata;
        `OFS_PERIOD_LO:  st_nxt.period[7:0]  = bus_req.wdata;
        `OFS_PERIOD_HI:  st_nxt.period[15:8] = bus_req.wdata;
        `OFS_IRQ_CTRL:   st_nxt.ovf_irq_en   = bus_req.wdata[`BIT_OVF_IRQ_EN];
        `OFS_DEAD_TIME:  st_nxt.dead         = bus_req.wdata;
        default: begin
          if (bus_req.addr >= `OFS_DUTY_BASE && bus_req.addr <= `OFS_DUTY_LAST) begin
            didx = bus_req.addr - `OFS_DUTY_BASE;
            if (didx[0]) begin
              st_nxt.duty[16*didx[3:1] +: 8] = bus_req.wdata;
            end else begin
              st_nxt.duty[16*didx[3:1] + 8 +: 8] = bus_req.wdata;
            end
          end
        end
      endcase
    end

    // Hardware set wins over a same-cycle software clear
    if (ovf) begin
      st_nxt.ovf_flag = 1'b1;
    end
    st_nxt.irq = st_r.ovf_flag && st_r.ovf_irq_en;

    // Register reads, data one cycle later
    st_nxt.rdata = 8'h00;
    if (bus_req.rd) begin
      case (bus_req.addr)
        `OFS_CH_INVERT:  st_nxt.rdata = st_r.invert;
        `OFS_MAIN_CTRL:  st_nxt.rdata = {st_r.run, st_r.ovf_flag, st_r.ckdiv, 2'h0, st_r.mode};
        `OFS_OUT_SELECT: st_nxt.rdata = st_r.out_sel;
        `OFS_PERIOD_LO:  st_nxt.rdata = st_r.period[7:0];
        `OFS_PERIOD_HI:  st_nxt.rdata = st_r.period[15:8];
        `OFS_IRQ_CTRL:   st_nxt.rdata = {7'h00, st_r.ovf_irq_en};
        `OFS_DEAD_TIME:  st_nxt.rdata = st_r.dead;
        default: begin
          if (bus_req.addr >= `OFS_DUTY_BASE && bus_req.addr <= `OFS_DUTY_LAST) begin
            didx = bus_req.addr - `OFS_DUTY_BASE;
            if (didx[0]) begin
              st_nxt.rdata = st_r.duty[16*didx[3:1] +: 8];
            end else begin
              st_nxt.rdata = st_r.duty[16*didx[3:1] + 8 +: 8];
            end
          end
        end
      endcase
    end
  end

  // ============================================================
  // State register
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      st_r              <= '0;
      st_r.pins.drive_n <= 8'hFF;
      st_r.dir          <= DIR_UP;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign bus_rdata = st_r.rdata;
  assign pins      = st_r.pins;
  assign irq       = st_r.irq;

endmodule

//--- multi_channel_pwm_core_tb.sv
`timescale 1ns/100ps
`define CHK(a, e) begin total_checks++; if ((a) !== (e)) begin n_mismatch++; \
  $display("[FAIL] %0t got %0h exp %0h", $time, (a), (e)); end end
module multi_channel_pwm_core_tb;
  import pwm_pkg::*;
  logic       clk = 1'b0;
  logic       resetn = 1'b0;
  bus_req_t   bus_req = '0;
  logic [7:0] bus_rdata;
  pin_drive_t pins;
  logic       irq;
  logic [7:0] rv;
  int         n_mismatch = 0;
  int         total_checks = 0;
  int         hi;
  int         per;

  always #4 clk = ~clk;

  multi_channel_pwm_core i_dut (.clk(clk), .resetn(resetn), .bus_req(bus_req),
    .bus_rdata(bus_rdata), .pins(pins), .irq(irq));

  // ==========================================
  // Bus and timing helpers
  task automatic cyc(input int n);
    bus_req <= '0;
    repeat (n) @(posedge clk);
  endtask
  // Leaves the strobe up so a read may follow with no gap
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    bus_req <= '{a, d, 1'b1, 1'b0};
    @(posedge clk);
  endtask
  task automatic rd(input logic [11:0] a);
    bus_req <= '{a, 8'h00, 1'b0, 1'b1};
    @(posedge clk);
    bus_req <= '0;
    @(posedge clk);
    rv = bus_rdata;
  endtask
  task automatic meas(input int c);
    hi = 0;
    per = 0;
    cyc(1);
    // Skip a whole period: the pins lag the counter, so a new setting shows late
    repeat (2) begin
      for (int n = 0; n < 300 && pins.level[c] !== 1'b0; n++) @(posedge clk);
      for (int n = 0; n < 300 && pins.level[c] !== 1'b1; n++) @(posedge clk);
    end
    while (per < 300 && pins.level[c] === 1'b1) begin
      hi++;
      per++;
      @(posedge clk);
    end
    while (per < 300 && pins.level[c] === 1'b0) begin
      per++;
      @(posedge clk);
    end
    if (per >= 300) begin
      n_mismatch++;
      stop_test();
    end
  endtask
  task automatic stop_test();
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // ==========================================
  // Scenarios
  task automatic t_regs();
    logic [11:0] ra[6] = '{12'h0D1, 12'h0D2, 12'h0D3, 12'h0D4, 12'h0D5, 12'h0D6};
    `CHK(pins.drive_n, 8'hFF)
    `CHK(irq, 1'b0)
    foreach (ra[i]) begin
      rd(ra[i]);
      `CHK(rv, 8'h00)
    end
    wr(12'h0D7, 8'hFF);
    rd(12'h0D7);
    `CHK(rv, 8'h00)
    wr(12'h0D1, 8'hA5);
    rd(12'h0D1);
    `CHK(rv, 8'hA5)
    wr(12'h0D2, 8'h3F);
    rd(12'h0D2);
    `CHK(rv, 8'h33)
    wr(12'h0D1, 8'h00);
    wr(12'h0D2, 8'h00);
  endtask
  task automatic t_edge();
    wr(12'h0D4, 8'h03);
    wr(12'h0D5, 8'h00);
    wr(12'h101, 8'h02);
    wr(12'h0D3, 8'h01);
    wr(12'h0D2, 8'h80);
    cyc(3);
    `CHK(pins.drive_n, 8'hFE)
    for (int k = 0; k < 4; k++) begin
      wr(12'h0D2, 8'h80 | 8'(k << 4));
      meas(0);
      `CHK(per, 4 << k)
      `CHK(hi, 2 << k)
    end
    wr(12'h0D2, 8'h81);
    meas(0);
    `CHK(per, 8)
    `CHK(hi, 3)
  endtask
  task automatic t_invert();
    wr(12'h0D2, 8'h80);
    wr(12'h101, 8'h01);
    wr(12'h103, 8'h03);
    wr(12'h0D3, 8'h03);
    wr(12'h0D1, 8'h01);
    meas(0);
    `CHK(hi, 3)
    meas(1);
    `CHK(hi, 3)
    `CHK(per, 4)
    wr(12'h0D1, 8'h00);
    wr(12'h0D8, 8'h00);
    wr(12'h0D2, 8'h82);
    cyc(8);
    for (int n = 0; n < 16; n++) begin
      `CHK(pins.level[1], ~pins.level[0])
      @(posedge clk);
    end
    // One clock of dead time, pulses long enough to survive it
    wr(12'h0D4, 8'h07);
    wr(12'h101, 8'h04);
    wr(12'h0D8, 8'h01);
    meas(0);
    `CHK(hi, 3)
    meas(1);
    `CHK(hi, 3)
    `CHK(per, 8)
    for (int n = 0; n < 16; n++) begin
      `CHK(pins.level[1] & pins.level[0], 1'b0)
      @(posedge clk);
    end
    wr(12'h0D2, 8'h83);
    meas(0);
    `CHK(per, 16)
    `CHK(hi, 6)
  endtask
  task automatic t_flag();
    // Clear the flag while stopped, so no overflow can refill it first
    wr(12'h0D2, 8'h00);
    wr(12'h0D3, 8'h00);
    wr(12'h0D2, 8'h80);
    wr(12'h0D6, 8'h01);
    for (int n = 0; n < 64 && irq !== 1'b1; n++) cyc(1);
    `CHK(irq, 1'b1)
    if (irq !== 1'b1) stop_test();
    `CHK(pins.drive_n, 8'hFF)
    bus_req <= '{12'h0D2, 8'h00, 1'b0, 1'b1};
    @(posedge clk);
    @(posedge clk);
    rv = bus_rdata;
    bus_req <= '0;
    @(posedge clk);
    `CHK(rv & bus_rdata & 8'h40, 8'h40)
    wr(12'h0D2, 8'h40);
    cyc(4);
    `CHK(irq, 1'b1)
    rd(12'h0D2);
    `CHK(rv, 8'h40)
    wr(12'h0D6, 8'h00);
    cyc(3);
    `CHK(irq, 1'b0)
    wr(12'h0D2, 8'h00);
    rd(12'h0D2);
    `CHK(rv, 8'h00)
  endtask

  initial begin
    repeat (12) @(posedge clk);
    resetn <= 1'b1;
    @(posedge clk);
    t_regs();
    t_edge();
    t_invert();
    t_flag();
    stop_test();
  end
endmodule

//--- pwm_channel.sv
`timescale 1ns/100ps

// Delays the rising edge of one waveform by a dead count of system clocks.
module pwm_channel (
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       resetn,
  // Waveform
  input  wire logic       wave_in,
  input  wire logic [7:0] dead_time,
  output logic            wave_out
);

  typedef struct packed {
    logic [7:0] dly;
    logic       out;
  } chan_state_t;

  chan_state_t st_r;
  chan_state_t st_nxt;

  always_comb begin
    st_nxt = st_r;
    if (!wave_in) begin
      st_nxt.dly = 8'h00;
      st_nxt.out = 1'b0;
    end else if (st_r.dly >= dead_time) begin
      st_nxt.out = 1'b1;
    end else begin
      st_nxt.dly = st_r.dly + 8'h01;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign wave_out = st_r.out;

endmodule

//--- pwm_core_chk_asserts.sv
`timescale 1ns/100ps
module pwm_core_chk (
  // Clock and reset
  input wire logic                clk,
  input wire logic                resetn,
  // Watched ports
  input wire pwm_pkg::bus_req_t   bus_req,
  input wire logic [7:0]          bus_rdata,
  input wire pwm_pkg::pin_drive_t pins,
  input wire logic                irq
);
  import pwm_pkg::*;
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  // ==========================================
  // Register port
  wire logic rd_ctl = bus_req.rd && bus_req.addr == 12'h0D2;
  wire logic wr_ctl = bus_req.wr && bus_req.addr == 12'h0D2;
  wire logic rd_inv = bus_req.rd && bus_req.addr == 12'h0D1;
  wire logic wr_inv = bus_req.wr && bus_req.addr == 12'h0D1;
  wire logic wr_ien = bus_req.wr && bus_req.addr == 12'h0D6;
  a_rdata_idle_zero: assert property (!$past(bus_req.rd) |-> bus_rdata == 8'h00)
    else $error("read data not zero");
  a_unmapped_read_zero: assert property (bus_req.rd && bus_req.addr == 12'h0D7 |=> bus_rdata == 8'h00)
    else $error("unmapped read");
  a_invert_readback: assert property (wr_inv ##1 rd_inv |=> bus_rdata == $past(bus_req.wdata, 2))
    else $error("invert readback");
  a_ctrl_readback: assert property (wr_ctl ##1 rd_ctl
    |=> (bus_rdata & 8'hBF) == ($past(bus_req.wdata, 2) & 8'hB3))
    else $error("control readback");
  // ==========================================
  // Flag, interrupt and pins
  a_flag_stays_set: assert property (rd_ctl ##1 (rd_ctl && bus_rdata[6]) |=> bus_rdata[6])
    else $error("flag cleared");
  a_irq_has_flag: assert property (rd_ctl && irq && !$past(bus_req.wr) |=> bus_rdata[6])
    else $error("irq without flag");
  a_irq_gate_off: assert property (wr_ien && !bus_req.wdata[0] |-> ##[1:3] !irq)
    else $error("irq not gated");
  a_stop_to_gpio: assert property (wr_ctl && !bus_req.wdata[7] |-> ##[1:3] pins.drive_n == 8'hFF)
    else $error("pins kept");
  cover property (irq);
  cover property (pins.drive_n != 8'hFF);
  cover property (rd_ctl ##1 bus_rdata[6]);
endmodule

bind multi_channel_pwm_core pwm_core_chk i_chk (.clk(clk), .resetn(resetn), .bus_req(bus_req),
  .bus_rdata(bus_rdata), .pins(pins), .irq(irq));

//--- pwm_pkg.sv
package pwm_pkg;

  typedef struct packed {
    logic [11:0] addr;
    logic [7:0]  wdata;
    logic        wr;
    logic        rd;
  } bus_req_t;

  typedef struct packed {
    logic [7:0] level;
    logic [7:0] drive_n;
  } pin_drive_t;

  typedef enum logic {
    DIR_UP,
    DIR_DOWN
  } count_dir_t;

endpackage

//--- pwm_regs.svh
`ifndef PWM_REGS_SVH
`define PWM_REGS_SVH

// ============================================================
// Register offsets
`define OFS_CH_INVERT    12'h0D1
`define OFS_MAIN_CTRL    12'h0D2
`define OFS_OUT_SELECT   12'h0D3
`define OFS_PERIOD_LO    12'h0D4
`define OFS_PERIOD_HI    12'h0D5
`define OFS_IRQ_CTRL     12'h0D6
`define OFS_DEAD_TIME    12'h0D8
// Duty words: base + 2*ch (high byte), base + 2*ch + 1 (low byte)
`define OFS_DUTY_BASE    12'h100
`define OFS_DUTY_LAST    12'h10F

// ============================================================
// Field positions of the main control register
`define BIT_MODULE_RUN   7
`define BIT_OVF_FLAG     6
`define BIT_CKDIV_HI     5
`define BIT_CKDIV_LO     4
`define BIT_MODE_COMP    1
`define BIT_MODE_CENTER  0
// Field position of the irq control register
`define BIT_OVF_IRQ_EN   0

// ============================================================
// Reset values
`define RST_BYTE         8'h00
`define RST_WORD         16'h0000
`define RST_DEAD         8'h00

// ============================================================
// Prescaler masks per divider code
`define DIV_MASK_1       3'h0
`define DIV_MASK_2       3'h1
`define DIV_MASK_4       3'h3
`define DIV_MASK_8       3'h7

`endif
